// >>> core/cvt_pkg.sv
package cvt_pkg;

  // Bit index of documented position p is 35 - p; position S (or P) is bit 35.
  localparam int WORD_W = 36;
  localparam int ADDR_W = 15;
  localparam int GROUP_W = 6;
  localparam int COUNT_W = 8;

  // Instruction fields.
  localparam int SIGN_POS = 35;
  localparam int OP_HI = 34;
  localparam int OP_LO = 24;
  localparam int COUNT_HI = 25;
  localparam int COUNT_LO = 18;
  localparam int TAG_STORE_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 0;

  // Six-bit groups at either end of a word.
  localparam int HIGH_GROUP_LO = 30;
  localparam int LOW_GROUP_HI = 5;

  localparam logic [10:0] OP_CODE_0114 = 11'h04c;
  localparam logic [10:0] OP_CODE_0154 = 11'h06c;
  localparam logic [COUNT_W-1:0] MAX_COUNT = 8'h06;
  localparam logic [COUNT_W-1:0] ONE_COUNT = 8'h01;
  localparam logic [COUNT_W-1:0] ZERO_COUNT = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_FETCH = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    MODE_REPLACE_ACC = 2'b00,
    MODE_REPLACE_QUOT = 2'b01,
    MODE_ADD_QUOT = 2'b10,
    MODE_NONE = 2'b11
  } mode_t;

endpackage : cvt_pkg

// >>> core/lookup_if.sv
`timescale 1ns/1ps
interface lookup_if;
  cvt_pkg::mode_t mode;
  logic apply;
  logic [35:0] acc;
  logic [35:0] quot;
  logic [35:0] word;
  logic [14:0] base;
  logic [35:0] acc_next;
  logic [35:0] quot_next;
  logic [14:0] addr_next;

  modport seq (output mode, apply, acc, quot, word, base, input acc_next, quot_next, addr_next);
  modport step (input mode, apply, acc, quot, word, base, output acc_next, quot_next, addr_next);
endinterface : lookup_if

// >>> core/lookup_step.sv
`timescale 1ns/1ps
// Computes one reference step: register update and the next table address.
module lookup_step (
  lookup_if.step lk
);

  function automatic logic [14:0] table_addr(input logic [14:0] base, input logic [5:0] group);
    table_addr = 15'(base + {9'h000, group});
  endfunction : table_addr

  logic [14:0] base_sel;

  always_comb begin
    lk.acc_next = lk.acc;
    lk.quot_next = lk.quot;
    // RULE5 next base
    base_sel = lk.apply ? lk.word[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO] : lk.base;
    if (lk.apply) begin
      case (lk.mode)
        // RULE4 shift and insert
        cvt_pkg::MODE_REPLACE_ACC: lk.acc_next = {lk.word[35:cvt_pkg::HIGH_GROUP_LO], lk.acc[35:6]};
        // RULE9 shift and load
        cvt_pkg::MODE_REPLACE_QUOT: lk.quot_next = {lk.quot[29:0], lk.word[35:cvt_pkg::HIGH_GROUP_LO]};
        cvt_pkg::MODE_ADD_QUOT: begin
          // RULE12 accumulate word
          lk.acc_next = 36'(lk.acc + lk.word);
          // RULE13 circular rotate
          lk.quot_next = {lk.quot[29:0], lk.quot[35:cvt_pkg::HIGH_GROUP_LO]};
        end
        default: lk.acc_next = lk.acc;
      endcase
    end
  end

  always_comb begin
    // RULE3 accumulator low group
    if (lk.mode == cvt_pkg::MODE_REPLACE_ACC) begin
      lk.addr_next = table_addr(base_sel, lk.acc_next[cvt_pkg::LOW_GROUP_HI:0]);
    end else begin
      // RULE8 quotient high group
      // RULE11 addition group
      lk.addr_next = table_addr(base_sel, lk.quot_next[35:cvt_pkg::HIGH_GROUP_LO]);
    end
  end

endmodule : lookup_step

// >>> core/table_lookup_convert_sequencer.sv
// What this block does
// RULE1: Opcode 0154 with minus sign decodes as replacement from the quotient register.
// RULE2: Opcode 0114 with minus sign decodes as addition from the quotient register.
// RULE3: Accumulator replacement adds accumulator low group to the base address.
// RULE4: Accumulator shifts right six; fetched high group fills the top.
// RULE5: Fetched word's address field is the next base; instruction address first.
// RULE6: Tag bit 20 stores the last table word address into index A.
// RULE7: Accumulator replacement takes one setup cycle then count execute cycles.
// RULE8: Quotient replacement adds quotient high group to the base address.
// RULE9: Quotient shifts left six; fetched high group loads its low end.
// RULE10: Quotient replacement takes one setup cycle plus count execute cycles.
// RULE11: Addition locates words with quotient high group plus base address.
// RULE12: Addition adds each fetched word into the accumulator, count times.
// RULE13: Addition rotates the quotient register left six, groups kept.
// RULE14: Opcode 0114 with plus sign decodes as accumulator replacement.
// RULE15: Count field sets references, at most six.
// RULE16: Tag positions 18 and 19 are ignored; only 20 matters.
// RULE17: Zero count ends after setup with no reference and no change.
`timescale 1ns/1ps
module table_lookup_convert_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [35:0] instr,
  input wire logic [35:0] acc_seed,
  input wire logic [35:0] quot_seed,
  input wire logic [35:0] mem_rdata,
  input wire logic mem_ack,
  output logic mem_req,
  output logic [14:0] mem_addr,
  output logic [35:0] acc_value,
  output logic [35:0] quot_value,
  output logic index_register_a_target_we,
  output logic [14:0] index_register_a_target,
  output logic busy,
  output logic done,
  output logic bad_opcode
);

  cvt_pkg::state_t state_reg;
  cvt_pkg::mode_t mode_reg;
  cvt_pkg::mode_t decoded_mode;
  logic [35:0] instr_reg;
  logic [35:0] accumulator_reg;
  logic [35:0] multiplier_quotient_reg;
  logic [14:0] base_reg;
  logic [14:0] addr_reg;
  logic [7:0] count_reg;
  logic [7:0] count_field;
  logic step_ack;
  logic take_start;

  lookup_if lk ();

  lookup_step u_step (
    .lk(lk.step)
  );

  assign step_ack = (state_reg == cvt_pkg::ST_FETCH) && mem_ack;
  assign take_start = state_reg == cvt_pkg::ST_IDLE && start && decoded_mode != cvt_pkg::MODE_NONE;
  assign lk.mode = mode_reg;
  assign lk.apply = step_ack;
  assign lk.acc = accumulator_reg;
  assign lk.quot = multiplier_quotient_reg;
  assign lk.word = mem_rdata;
  assign lk.base = base_reg;

  always_comb begin
    decoded_mode = cvt_pkg::MODE_NONE;
    if (instr[cvt_pkg::OP_HI:cvt_pkg::OP_LO] == cvt_pkg::OP_CODE_0114) begin
      // RULE2 minus form
      // RULE14 plus form
      decoded_mode = instr[cvt_pkg::SIGN_POS] ? cvt_pkg::MODE_ADD_QUOT : cvt_pkg::MODE_REPLACE_ACC;
    end else if (instr[cvt_pkg::OP_HI:cvt_pkg::OP_LO] == cvt_pkg::OP_CODE_0154 && instr[cvt_pkg::SIGN_POS]) begin
      // RULE1 quotient replacement
      decoded_mode = cvt_pkg::MODE_REPLACE_QUOT;
    end
  end

  // RULE15 count clamp
  assign count_field = (instr_reg[cvt_pkg::COUNT_HI:cvt_pkg::COUNT_LO] > cvt_pkg::MAX_COUNT) ?
                       cvt_pkg::MAX_COUNT : instr_reg[cvt_pkg::COUNT_HI:cvt_pkg::COUNT_LO];

  // RULE7 setup then execute
  // RULE10 same sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= cvt_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        cvt_pkg::ST_IDLE: begin
          if (start && decoded_mode != cvt_pkg::MODE_NONE) begin
            state_reg <= cvt_pkg::ST_SETUP;
          end
        end
        cvt_pkg::ST_SETUP: begin
          // RULE17 zero count
          state_reg <= (count_field == cvt_pkg::ZERO_COUNT) ? cvt_pkg::ST_IDLE : cvt_pkg::ST_FETCH;
        end
        cvt_pkg::ST_FETCH: begin
          if (mem_ack && count_reg == cvt_pkg::ONE_COUNT) begin
            state_reg <= cvt_pkg::ST_IDLE;
          end
        end
        default: state_reg <= cvt_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= cvt_pkg::MODE_NONE;
      instr_reg <= cvt_pkg::WORD_RESET;
    end else if (state_reg == cvt_pkg::ST_IDLE && start && decoded_mode != cvt_pkg::MODE_NONE) begin
      mode_reg <= decoded_mode;
      instr_reg <= instr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= cvt_pkg::ZERO_COUNT;
    end else if (state_reg == cvt_pkg::ST_SETUP) begin
      count_reg <= count_field;
    end else if (step_ack) begin
      count_reg <= 8'(count_reg - cvt_pkg::ONE_COUNT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      accumulator_reg <= cvt_pkg::WORD_RESET;
      multiplier_quotient_reg <= cvt_pkg::WORD_RESET;
    end else if (state_reg == cvt_pkg::ST_IDLE && start && decoded_mode != cvt_pkg::MODE_NONE) begin
      accumulator_reg <= acc_seed;
      multiplier_quotient_reg <= quot_seed;
    end else if (step_ack) begin
      accumulator_reg <= lk.acc_next;
      multiplier_quotient_reg <= lk.quot_next;
    end
  end

  // RULE5 base chaining
  // The instruction address is loaded with the start, so the setup cycle already adds to it.
  always_ff @(posedge clk) begin
    if (rst) begin
      base_reg <= cvt_pkg::ADDR_RESET;
    end else if (take_start) begin
      base_reg <= instr[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO];
    end else if (step_ack) begin
      base_reg <= mem_rdata[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO];
    end
  end

  // RULE3 table address
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg <= cvt_pkg::ADDR_RESET;
    end else if (state_reg == cvt_pkg::ST_SETUP || step_ack) begin
      addr_reg <= lk.addr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      bad_opcode <= 1'b0;
      index_register_a_target_we <= 1'b0;
      index_register_a_target <= cvt_pkg::ADDR_RESET;
    end else begin
      done <= (state_reg == cvt_pkg::ST_SETUP && count_field == cvt_pkg::ZERO_COUNT) ||
              (step_ack && count_reg == cvt_pkg::ONE_COUNT);
      bad_opcode <= state_reg == cvt_pkg::ST_IDLE && start && decoded_mode == cvt_pkg::MODE_NONE;
      // RULE6 index store
      // RULE16 only bit 20
      index_register_a_target_we <= step_ack && count_reg == cvt_pkg::ONE_COUNT &&
                                    instr_reg[cvt_pkg::TAG_STORE_POS];
      if (step_ack && count_reg == cvt_pkg::ONE_COUNT && instr_reg[cvt_pkg::TAG_STORE_POS]) begin
        index_register_a_target <= mem_rdata[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO];
      end
    end
  end

  assign mem_req = state_reg == cvt_pkg::ST_FETCH;
  assign mem_addr = addr_reg;
  assign acc_value = accumulator_reg;
  assign quot_value = multiplier_quotient_reg;
  assign busy = state_reg != cvt_pkg::ST_IDLE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  decode_quot_a: assert property ( // RULE1
    state_reg == cvt_pkg::ST_IDLE && start && instr[cvt_pkg::SIGN_POS] &&
    instr[cvt_pkg::OP_HI:cvt_pkg::OP_LO] == cvt_pkg::OP_CODE_0154
    |=> state_reg == cvt_pkg::ST_SETUP && mode_reg == cvt_pkg::MODE_REPLACE_QUOT)
    else $error("quotient replace not decoded");
  decode_add_a: assert property ( // RULE2
    state_reg == cvt_pkg::ST_IDLE && start && instr[cvt_pkg::SIGN_POS] &&
    instr[cvt_pkg::OP_HI:cvt_pkg::OP_LO] == cvt_pkg::OP_CODE_0114
    |=> mode_reg == cvt_pkg::MODE_ADD_QUOT)
    else $error("add from quotient not decoded");
  decode_acc_a: assert property ( // RULE14
    state_reg == cvt_pkg::ST_IDLE && start && !instr[cvt_pkg::SIGN_POS] &&
    instr[cvt_pkg::OP_HI:cvt_pkg::OP_LO] == cvt_pkg::OP_CODE_0114
    |=> mode_reg == cvt_pkg::MODE_REPLACE_ACC)
    else $error("acc replace not decoded");
  setup_once_a: assert property ( // RULE7
    state_reg == cvt_pkg::ST_SETUP |=> state_reg != cvt_pkg::ST_SETUP && count_reg <= cvt_pkg::MAX_COUNT)
    else $error("setup not single or count too big");
  first_addr_a: assert property ( // RULE3
    state_reg == cvt_pkg::ST_SETUP |=> addr_reg == 15'(instr_reg[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO] +
    (mode_reg == cvt_pkg::MODE_REPLACE_ACC ? {9'h000, accumulator_reg[cvt_pkg::LOW_GROUP_HI:0]} :
    {9'h000, multiplier_quotient_reg[35:cvt_pkg::HIGH_GROUP_LO]})))
    else $error("first table address wrong");
  acc_shift_a: assert property ( // RULE4
    step_ack && mode_reg == cvt_pkg::MODE_REPLACE_ACC
    |=> accumulator_reg == {$past(mem_rdata[35:cvt_pkg::HIGH_GROUP_LO]), $past(accumulator_reg[35:6])} &&
    addr_reg == 15'($past(mem_rdata[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO]) +
    {9'h000, accumulator_reg[cvt_pkg::LOW_GROUP_HI:0]}))
    else $error("acc step wrong");
  quot_replace_a: assert property ( // RULE9
    step_ack && mode_reg == cvt_pkg::MODE_REPLACE_QUOT
    |=> multiplier_quotient_reg == {$past(multiplier_quotient_reg[29:0]),
    $past(mem_rdata[35:cvt_pkg::HIGH_GROUP_LO])})
    else $error("quotient replace wrong");
  quot_addr_a: assert property ( // RULE5
    step_ack && mode_reg != cvt_pkg::MODE_REPLACE_ACC
    |=> addr_reg == 15'($past(mem_rdata[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO]) +
    {9'h000, multiplier_quotient_reg[35:cvt_pkg::HIGH_GROUP_LO]}))
    else $error("quotient address wrong");
  add_step_a: assert property ( // RULE12
    step_ack && mode_reg == cvt_pkg::MODE_ADD_QUOT
    |=> accumulator_reg == 36'($past(accumulator_reg) + $past(mem_rdata)) &&
    multiplier_quotient_reg == {$past(multiplier_quotient_reg[29:0]),
    $past(multiplier_quotient_reg[35:cvt_pkg::HIGH_GROUP_LO])})
    else $error("add step wrong");
  zero_count_a: assert property ( // RULE17
    state_reg == cvt_pkg::ST_SETUP && count_field == cvt_pkg::ZERO_COUNT
    |=> done && !mem_req && $stable(accumulator_reg) && $stable(multiplier_quotient_reg))
    else $error("zero count misbehaves");
  index_store_a: assert property ( // RULE6
    index_register_a_target_we
    |-> done && instr_reg[cvt_pkg::TAG_STORE_POS] &&
    index_register_a_target == $past(mem_rdata[cvt_pkg::ADDR_HI:cvt_pkg::ADDR_LO]))
    else $error("index store wrong");

  full_acc_c: cover property (mode_reg == cvt_pkg::MODE_REPLACE_ACC && done &&
    instr_reg[cvt_pkg::COUNT_HI:cvt_pkg::COUNT_LO] == cvt_pkg::MAX_COUNT);
  quot_replace_c: cover property (mode_reg == cvt_pkg::MODE_REPLACE_QUOT && done);
  add_tag_c: cover property (mode_reg == cvt_pkg::MODE_ADD_QUOT && index_register_a_target_we);
  zero_done_c: cover property (state_reg == cvt_pkg::ST_SETUP && count_field == cvt_pkg::ZERO_COUNT);

endmodule : table_lookup_convert_sequencer

// >>> test/table_store_model.sv
`timescale 1ns/1ps
// Behavioural table storage; each request is answered promptly or after up to three idle cycles.
module table_store_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [14:0] mem_addr,
  output logic mem_ack,
  output logic [35:0] mem_rdata
);
  int wait_reg;
  logic [35:0] last_reg;

  function automatic logic [35:0] word_at(input logic [14:0] a);
    logic [14:0] g;
    g = a * 15'h0007 + 15'h0003;
    return {g[5:0], a ^ 15'h1b5d, a * 15'h0005 + 15'h000b};
  endfunction : word_at

  // Outside an answer the data lines show the inverse of the last word, never a stale copy.
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_reg <= 0;
      last_reg <= 36'h000000000;
      mem_rdata <= 36'h000000000;
    end else if (mem_req && !mem_ack && wait_reg == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= word_at(mem_addr);
      last_reg <= word_at(mem_addr);
      wait_reg <= slow ? int'($urandom_range(3)) : 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~last_reg;
      if (mem_req && wait_reg > 0) begin
        wait_reg <= wait_reg - 1;
      end
    end
  end
endmodule : table_store_model

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst;
  logic start;
  logic slow;
  logic [35:0] instr;
  logic [35:0] acc_in;
  logic [35:0] quo_in;
  logic [35:0] mem_rdata;
  logic mem_ack;
  logic mem_req;
  logic [14:0] mem_addr;
  logic [35:0] acc_out;
  logic [35:0] quo_out;
  logic idx_we;
  logic [14:0] idx_value;
  logic busy;
  logic done;
  logic bad_opcode;
  int bad_count;
  int samples_checked;
  int corner_counts[5] = '{0, 1, 6, 7, 63};

  table_lookup_convert_sequencer table_lookup_convert_sequencer_inst (.clk(clk), .rst(rst), .start(start),
    .instr(instr), .acc_seed(acc_in), .quot_seed(quo_in), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_req(mem_req), .mem_addr(mem_addr), .acc_value(acc_out), .quot_value(quo_out),
    .index_register_a_target_we(idx_we), .index_register_a_target(idx_value), .busy(busy), .done(done),
    .bad_opcode(bad_opcode));
  table_store_model table_store_model_inst (.clk(clk), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check

  // Mode 0 replaces from the accumulator, 1 replaces from the quotient, 2 adds from the quotient.
  task automatic run(input int mode, input int cnt, input logic tag, input logic [14:0] base,
    input logic [35:0] a, input logic [35:0] q);
    logic [35:0] w;
    logic [14:0] exp_addr [6];
    logic [14:0] ad;
    logic [35:0] ea;
    logic [35:0] eq;
    int n;
    int refs;
    int last;
    int cyc;
    n = cnt > 6 ? 6 : cnt;
    ea = a;
    eq = q;
    ad = base;
    w = 36'h000000000;
    for (int i = 0; i < n; i++) begin
      exp_addr[i] = ad + (mode == 0 ? 15'(ea[5:0]) : 15'(eq[35:30]));
      w = table_store_model_inst.word_at(exp_addr[i]);
      if (mode == 0) ea = {w[35:30], ea[35:6]};
      else if (mode == 1) eq = {eq[29:0], w[35:30]};
      else begin
        ea = ea + w;
        eq = {eq[29:0], eq[35:30]};
      end
      ad = w[14:0];
    end
    instr = {mode != 0, mode == 1 ? cvt_pkg::OP_CODE_0154 : cvt_pkg::OP_CODE_0114, 24'h000000};
    instr[25:18] = 8'(cnt);
    instr[17:16] = 2'($urandom);
    instr[15] = tag;
    instr[14:0] = base;
    acc_in = a;
    quo_in = q;
    start = 1'b1;
    refs = 0;
    last = 0;
    cyc = 0;
    while (cyc < 60) begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc == 1) start = 1'b0;
      if (cyc == 1) check("busy", 36'h1, 36'(busy));
      // A start while busy must be ignored, and changed operands must not be taken.
      if (cyc == 3 && n > 1) begin
        start = 1'b1;
        acc_in = ~a;
        quo_in = ~q;
      end
      if (cyc == 4) start = 1'b0;
      if (bad_opcode !== 1'b0) check("bad_opcode", 36'h0, 36'(bad_opcode));
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
        if (refs < 6) check("mem_addr", 36'(exp_addr[refs]), 36'(mem_addr));
        refs++;
        last = cyc;
      end
      if (done === 1'b1) break;
    end
    check("done", 36'h1, 36'(done));
    check("refs", 36'(n), 36'(refs));
    check("latency", 36'(n == 0 ? 2 : last + 1), 36'(cyc));
    check("acc_value", ea, acc_out);
    check("quot_value", eq, quo_out);
    check("store_we", 36'(tag && n > 0), 36'(idx_we));
    if (tag && n > 0) check("store_addr", 36'(w[14:0]), 36'(idx_value));
  endtask : run

  task automatic refuse(input logic [35:0] word);
    instr = word;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    check("bad_opcode", 36'h1, 36'(bad_opcode));
    @(posedge clk);
    #1;
    check("busy_refused", 36'h0, 36'(busy));
  endtask : refuse

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The whole run needs about 1000 cycles; this limit is fifty times that.
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    instr = 36'h000000000;
    acc_in = 36'h000000000;
    quo_in = 36'h000000000;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'heeba));
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    check("reset_acc", 36'h0, acc_out);
    check("reset_busy", 36'h0, 36'(busy));
    // The first start waits for the edge that sees reset low, then is driven right after it.
    @(posedge clk);
    #1;
    for (int m = 0; m < 3; m++) begin
      foreach (corner_counts[k]) run(m, corner_counts[k], 1'(k), 15'h7ffc, 36'hfffffffff, 36'h000000000);
    end
    refuse({1'b0, cvt_pkg::OP_CODE_0154, 24'h000000});
    refuse({1'b1, 11'h001, 24'h000000});
    slow = 1'b1;
    repeat (60) begin
      run(int'($urandom_range(2)), int'($urandom_range(9)), 1'($urandom), 15'($urandom),
        {$urandom, 4'($urandom)}, {$urandom, 4'($urandom)});
    end
    stop_test();
  end
endmodule : tb
